// [design/io_pkg.sv]
/*
  shared constants, register map and helpers for the port access unit
  and the external port decoder. assumes a single 100 mhz clock domain.
*/
package io_pkg;
  // i/o space: 64k byte ports, top port number
  localparam logic [15:0] PORT_TOP = 16'hffff;
  localparam logic [13:0] TOP_WORD = 14'h3fff;
  // reserved ports, never decoded by system hardware
  localparam logic [15:0] RSV_LO = 16'h00f8;
  localparam logic [15:0] RSV_HI = 16'h00ff;
  // axi4-lite register map of the unit (byte addresses)
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PORT = 8'h04;
  localparam logic [7:0] OFF_IMM = 8'h08;
  localparam logic [7:0] OFF_ACC = 8'h0c;
  localparam logic [7:0] OFF_CNT = 8'h10;
  localparam logic [7:0] OFF_SRC = 8'h14;
  localparam logic [7:0] OFF_DST = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1c;
  localparam logic [7:0] OFF_MAP = 8'h40;
  localparam logic [7:0] MAP_END = 8'h60;
  localparam logic [7:0] OFF_BUF = 8'h80;
  localparam logic [7:0] BUF_END = 8'hc0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control register fields
  localparam int unsigned CTL_W = 15;
  localparam int unsigned CTL_GO = 0;
  localparam int unsigned CTL_WR = 1;
  localparam int unsigned CTL_SZ = 2;
  localparam int unsigned CTL_STR = 4;
  localparam int unsigned CTL_RPT = 5;
  localparam int unsigned CTL_DIR = 6;
  localparam int unsigned CTL_IMM = 7;
  localparam int unsigned CTL_MEM = 8;
  localparam int unsigned CTL_NOCACHE = 9;
  localparam int unsigned CTL_PROT = 10;
  localparam int unsigned CTL_CUR_LVL = 11;
  localparam int unsigned CTL_PORT_LVL = 13;
  // status register fields
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_FAULT = 1;
  localparam int unsigned ST_PAR = 2;
  localparam int unsigned ST_CACHE = 3;
  localparam int unsigned ST_DONE = 4;
  // transfer size codes
  localparam logic [1:0] SZ_8 = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam logic [1:0] SZ_32 = 2'h2;
  // storage sizes
  localparam int unsigned MAP_PORTS = 256;
  localparam int unsigned BUF_BYTES = 64;
  localparam int unsigned DEC_WORDS = 16;

  // bytes moved per item
  function automatic logic [2:0] sz_bytes(input logic [1:0] sz);
    case (sz)
      SZ_16: sz_bytes = 3'h2;
      SZ_32: sz_bytes = 3'h4;
      default: sz_bytes = 3'h1;
    endcase
  endfunction : sz_bytes

  // byte lanes of an item at offset zero
  function automatic logic [7:0] sz_lanes(input logic [1:0] sz);
    case (sz)
      SZ_16: sz_lanes = 8'h03;
      SZ_32: sz_lanes = 8'h0f;
      default: sz_lanes = 8'h01;
    endcase
  endfunction : sz_lanes

  // accumulator bits touched by an item
  function automatic logic [31:0] sz_mask32(input logic [1:0] sz);
    case (sz)
      SZ_16: sz_mask32 = 32'h0000ffff;
      SZ_32: sz_mask32 = 32'hffffffff;
      default: sz_mask32 = 32'h000000ff;
    endcase
  endfunction : sz_mask32

  // merge a word under byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : apply_strb
endpackage : io_pkg

// [design/io_link_if.sv]
/*
  port bus between the access unit and the external decoder.
  assumes both ends run on aclk; wire levels need no resolution.
*/
interface io_link_if (
  input wire logic aclk,
  input wire logic aresetn
);
  logic req; // cycle request, held until ready
  logic mem_io; // 1 memory cycle, 0 i/o cycle
  logic write; // 1 write, 0 read
  logic [15:0] addr; // word aligned address
  logic [3:0] be; // byte lanes of this cycle
  logic [31:0] wdata; // write data by lane
  logic [31:0] rdata; // read data, valid with ready
  logic ready; // one-cycle end of cycle
  logic parity_err; // parity fault, valid with ready
  logic cache_enable_input_n; // high: do not cache

  modport cpu (
    input aclk,
    input aresetn,
    output req,
    output mem_io,
    output write,
    output addr,
    output be,
    output wdata,
    input rdata,
    input ready,
    input parity_err,
    input cache_enable_input_n
  );

  modport dec (
    input aclk,
    input aresetn,
    input req,
    input mem_io,
    input write,
    input addr,
    input be,
    input wdata,
    output rdata,
    output ready,
    output parity_err,
    output cache_enable_input_n
  );
endinterface : io_link_if

// [design/io_port_decoder.sv]
/*
  external address decoder with a small bank of port registers and a
  memory-mapped window. assumes the unit holds each cycle until ready.
*/
module io_port_decoder (
  io_link_if.dec link,
  output logic [31:0] user_port_out,
  input wire logic [31:0] user_port_in,
  input wire logic user_parity_inject
);
  import io_pkg::*;

  // all decoder state
  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
    logic par;
    logic cen_n;
    logic [DEC_WORDS*32-1:0] ports;
    logic [DEC_WORDS*32-1:0] mem;
  } dec_s;

  dec_s q; // registered state
  dec_s d; // next state

  assign link.ready = q.ready;
  assign link.rdata = q.rdata;
  assign link.parity_err = q.par;
  assign link.cache_enable_input_n = q.cen_n;
  assign user_port_out = q.ports[31:0];

  // decode one cycle, answer one clock later
  always_comb begin
    logic hit;
    logic rsv;
    logic [3:0] k;
    hit = 1'b0;
    rsv = 1'b0;
    k = link.addr[5:2];
    d = q;
    d.ready = 1'b0;
    d.par = 1'b0;
    if (link.req && !q.ready) begin
      d.ready = 1'b1;
      d.rdata = 32'h00000000;
      d.par = user_parity_inject;
      hit = (link.addr[15:2] < 14'(DEC_WORDS));
      // reserved numbers stay unassigned
      rsv = (link.addr >= {RSV_LO[15:2], 2'b00}) && (link.addr <= RSV_HI);
      if (link.mem_io) begin
        // mapped window kept out of any cache
        d.cen_n = hit;
        if (hit && link.write) begin
          d.mem[32*k +: 32] = apply_strb(q.mem[32*k +: 32], link.wdata,
                                         link.be);
        end else if (hit) begin
          d.rdata = q.mem[32*k +: 32];
        end
      end else begin
        // i/o cycle selects ports, not memory
        d.cen_n = 1'b1;
        if (hit && !rsv && link.write) begin
          // each byte lane lands in its own port
          d.ports[32*k +: 32] = apply_strb(q.ports[32*k +: 32],
                                           link.wdata, link.be);
        end else if (hit && !rsv && k == 4'h1) begin
          d.rdata = user_port_in;
        end else if (hit && !rsv) begin
          d.rdata = q.ports[32*k +: 32];
        end
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : io_port_decoder

// [design/io_port_unit.sv]
/*
  processor-side port access unit: register and string port transfers,
  alignment splitting, privilege gating, cycle type and cache marking.
  assumes an axi4-lite master and a decoder on io_link_if.
*/
// Our own choices: the address map and the AXI4-Lite slave port.
module io_port_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [io_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [io_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  io_link_if.cpu link
);
  import io_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_CYC, S_FIN} state_e;

  // all unit state
  typedef struct packed {
    state_e st;
    logic aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [CTL_W-1:0] ctl;
    logic [15:0] port;
    logic [15:0] imm;
    logic [31:0] acc;
    logic [31:0] cnt;
    logic [31:0] src;
    logic [31:0] dst;
    logic fault;
    logic par;
    logic cache;
    logic done;
    logic [MAP_PORTS-1:0] map;
    logic [BUF_BYTES*8-1:0] buf_mem;
    logic req;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] dat;
    logic [7:0] mask;
    logic [63:0] wide;
    logic [63:0] rd;
    logic phase;
    logic [1:0] off;
  } unit_s;

  unit_s q; // registered state
  unit_s d; // next state

  // bitmap test over all covered byte ports
  function automatic logic denied(input logic [MAP_PORTS-1:0] map,
                                  input logic [15:0] pa,
                                  input logic [2:0] nb);
    logic r;
    logic [16:0] p;
    r = 1'b0;
    for (int i = 0; i < 4; i++) begin
      p = {1'b0, pa} + 17'(i);
      if (3'(i) < nb) begin
        // ports past the map count as set
        r = r | ((p >= 17'(MAP_PORTS)) ? 1'b1 : map[p[7:0]]);
      end
    end
    return r;
  endfunction : denied

  // true for any mapped register word
  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = (a <= OFF_STAT) || (a >= OFF_MAP && a < MAP_END) ||
             (a >= OFF_BUF && a < BUF_END);
  endfunction : mapped

  // handshake outputs
  assign awready = !q.aw_got && !q.bvalid;
  assign wready = !q.w_got && !q.bvalid;
  assign arready = !q.rvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  // cycle outputs come straight from flops
  assign link.req = q.req;
  assign link.mem_io = q.ctl[CTL_MEM]; // low for port ops
  assign link.write = q.ctl[CTL_WR];
  assign link.addr = q.addr;
  assign link.be = q.be;
  assign link.wdata = q.dat;

  // bus slave, then the transfer engine
  always_comb begin
    logic [AXI_AW-1:0] a;
    logic [31:0] wv;
    logic [15:0] pa;
    logic [2:0] nb;
    logic [7:0] m8;
    logic [63:0] rv;
    logic [31:0] ev;
    logic [31:0] szm;
    logic [31:0] step;
    logic str;
    logic rpt;
    logic [5:0] bi;
    logic [5:0] bx;
    a = {q.aw_addr[AXI_AW-1:2], 2'b00};
    wv = 32'h00000000;
    pa = 16'h0000;
    nb = sz_bytes(q.ctl[CTL_SZ +: 2]);
    m8 = 8'h00;
    rv = 64'h0;
    ev = 32'h00000000;
    szm = sz_mask32(q.ctl[CTL_SZ +: 2]);
    step = {29'h0, nb};
    str = q.ctl[CTL_STR];
    rpt = q.ctl[CTL_RPT] && q.ctl[CTL_STR];
    bi = 6'h00;
    bx = 6'h00;
    d = q;
    // address and data channels taken in either order
    if (awvalid && awready) begin
      d.aw_got = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      d.w_got = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    // register write once both halves are in
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(a) ? RESP_OKAY : RESP_SLVERR;
      if (a == OFF_CTRL && q.st == S_IDLE) begin
        wv = apply_strb({17'h0, q.ctl}, q.w_data, q.w_strb);
        d.ctl = wv[CTL_W-1:0];
        d.ctl[CTL_GO] = 1'b0;
        if (wv[CTL_GO]) begin
          d.st = S_SETUP;
        end
      end else if (a == OFF_PORT) begin
        wv = apply_strb({16'h0, q.port}, q.w_data, q.w_strb);
        d.port = wv[15:0];
      end else if (a == OFF_IMM) begin
        wv = apply_strb({16'h0, q.imm}, q.w_data, q.w_strb);
        d.imm = wv[15:0];
      end else if (a == OFF_ACC) begin
        d.acc = apply_strb(q.acc, q.w_data, q.w_strb);
      end else if (a == OFF_CNT) begin
        d.cnt = apply_strb(q.cnt, q.w_data, q.w_strb);
      end else if (a == OFF_SRC) begin
        d.src = apply_strb(q.src, q.w_data, q.w_strb);
      end else if (a == OFF_DST) begin
        d.dst = apply_strb(q.dst, q.w_data, q.w_strb);
      end else if (a == OFF_STAT) begin
        // write one to clear; engine sets below win
        d.fault = q.fault && !q.w_data[ST_FAULT];
        d.par = q.par && !q.w_data[ST_PAR];
        d.done = q.done && !q.w_data[ST_DONE];
      end else if (a >= OFF_MAP && a < MAP_END) begin
        d.map[32*a[4:2] +: 32] = apply_strb(q.map[32*a[4:2] +: 32],
                                            q.w_data, q.w_strb);
      end else if (a >= OFF_BUF && a < BUF_END) begin
        d.buf_mem[32*a[5:2] +: 32] = apply_strb(q.buf_mem[32*a[5:2] +: 32],
                                                q.w_data, q.w_strb);
      end
    end
    // register read, answered next cycle
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      // low address bits ignored, as on the write side
      d.rresp = mapped({araddr[AXI_AW-1:2], 2'b00}) ? RESP_OKAY :
                RESP_SLVERR;
      d.rdata = 32'h00000000;
      case ({araddr[AXI_AW-1:2], 2'b00})
        OFF_CTRL: d.rdata = {17'h0, q.ctl};
        OFF_PORT: d.rdata = {16'h0, q.port};
        OFF_IMM: d.rdata = {16'h0, q.imm};
        OFF_ACC: d.rdata = q.acc;
        OFF_CNT: d.rdata = q.cnt;
        OFF_SRC: d.rdata = q.src;
        OFF_DST: d.rdata = q.dst;
        OFF_STAT: d.rdata = {27'h0, q.done, q.cache, q.par, q.fault,
                             q.st != S_IDLE};
        default: begin
          if (araddr >= OFF_MAP && araddr < MAP_END) begin
            d.rdata = q.map[32*araddr[4:2] +: 32];
          end else if (araddr >= OFF_BUF && araddr < BUF_END) begin
            d.rdata = q.buf_mem[32*araddr[5:2] +: 32];
          end
        end
      endcase
    end
    // transfer engine
    case (q.st)
      S_IDLE: begin
        d.req = 1'b0;
      end
      S_SETUP: begin
        // immediate only for register forms
        pa = (q.ctl[CTL_IMM] && !str) ? q.imm : q.port;
        if (rpt && q.cnt == 32'h0) begin
          d.st = S_IDLE;
          d.done = 1'b1;
        end else if (!q.ctl[CTL_MEM] && q.ctl[CTL_PROT] &&
                     q.ctl[CTL_CUR_LVL +: 2] > q.ctl[CTL_PORT_LVL +: 2] &&
                     denied(q.map, pa, nb)) begin
          // fault, no cycle issued
          d.fault = 1'b1;
          d.st = S_IDLE;
        end else begin
          // byte lanes of one or two words
          m8 = sz_lanes(q.ctl[CTL_SZ +: 2]) << pa[1:0];
          if (pa[15:2] == TOP_WORD) begin
            m8[7:4] = 4'h0; // nothing issued past the top
          end
          bi = q.src[5:0];
          for (int i = 0; i < 4; i++) begin
            bx = bi + 6'(i); // index wraps inside the buffer
            ev[8*i +: 8] = q.buf_mem[8*bx +: 8];
          end
          // output source: buffer via source pointer for string writes, else accumulator
          ev = (str && q.ctl[CTL_WR]) ? ev : q.acc;
          d.wide = {32'h0, ev} << {pa[1:0], 3'b000};
          d.mask = m8;
          d.off = pa[1:0];
          d.phase = 1'b0;
          d.rd = 64'h0;
          d.req = 1'b1;
          d.addr = {pa[15:2], 2'b00};
          d.be = m8[3:0];
          d.dat = d.wide[31:0];
          d.st = S_CYC;
        end
      end
      S_CYC: begin
        if (link.ready) begin
          d.req = 1'b0;
          if (link.parity_err) begin
            d.par = 1'b1; // never masked for i/o cycles
          end
          // cache only memory cycles with both enables
          d.cache = q.ctl[CTL_MEM] && !q.ctl[CTL_NOCACHE] &&
                    !link.cache_enable_input_n;
          if (!q.phase) begin
            d.rd[31:0] = link.rdata;
          end else begin
            d.rd[63:32] = link.rdata;
          end
          if (!q.phase && q.mask[7:4] != 4'h0) begin
            // unaligned: second cycle
            d.phase = 1'b1;
            d.req = 1'b1;
            d.addr = q.addr + 16'h0004;
            d.be = q.mask[7:4];
            d.dat = q.wide[63:32];
          end else begin
            d.st = S_FIN; // aligned ends in one cycle
          end
        end
      end
      S_FIN: begin
        rv = q.rd >> {q.off, 3'b000};
        if (!q.ctl[CTL_WR] && str) begin
          // input lands at destination pointer
          bi = q.dst[5:0];
          for (int i = 0; i < 4; i++) begin
            if (3'(i) < nb) begin
              bx = bi + 6'(i); // index wraps inside the buffer
              d.buf_mem[8*bx +: 8] = rv[8*i +: 8];
            end
          end
        end else if (!q.ctl[CTL_WR]) begin
          d.acc = (q.acc & ~szm) | (rv[31:0] & szm);
        end
        if (str && q.ctl[CTL_WR]) begin
          // step per item by direction flag
          d.src = q.ctl[CTL_DIR] ? q.src - step : q.src + step;
        end else if (str) begin
          d.dst = q.ctl[CTL_DIR] ? q.dst - step : q.dst + step;
        end
        if (rpt) begin
          d.cnt = q.cnt - 32'h1;
        end
        if (rpt && q.cnt != 32'h1) begin
          d.st = S_SETUP;
        end else begin
          // done after the last cycle ended, or in setup with no cycle when a repeat count is zero
          d.st = S_IDLE;
          d.done = 1'b1;
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : io_port_unit

// [verif/io_link_assertions.sv]
/* checks on the port bus between the unit and the decoder.
   assumes one clock domain; placed beside the interface instance. */
module io_link_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic mem_io,
  input wire logic write,
  input wire logic [15:0] addr,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ready,
  input wire logic parity_err,
  input wire logic cache_enable_input_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // cycle offered, not yet answered
  sequence s_open;
    req && !ready;
  endsequence
  // answer closing the cycle
  sequence s_answer;
    ready && req;
  endsequence
  AST_HOLD: assert property (s_open |=>
    $stable({mem_io, write, addr, be, wdata}))
    else $error("cycle fields moved before ready");
  AST_ANSWER: assert property (s_open |=> s_answer)
    else $error("no ready one cycle after request");
  AST_PULSE: assert property (s_answer |=> !ready)
    else $error("ready longer than one cycle");
  AST_NO_STRAY: assert property (!req |-> !ready)
    else $error("ready without a request");
  AST_ALIGN: assert property (req |-> addr[1:0] == 2'h0)
    else $error("cycle address not word aligned");
  AST_LANES: assert property (req |-> be inside
    {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf})
    else $error("byte lanes not contiguous");
  AST_RSV: assert property (s_answer ##0 (!mem_io && !write
    && addr[15:3] == 13'h001f) |-> rdata == 32'h0)
    else $error("reserved port returned data");
  AST_CACHE: assert property (s_answer ##0 mem_io |->
    cache_enable_input_n == (addr < 16'h0040))
    else $error("cache marking wrong for window");
endmodule : io_link_assertions

// [verif/test_io_port_access_unit.sv]
/* self-checking bench: unit and decoder joined by the port bus.
   assumes the unit's own register map and its bus latencies. */
module test_io_port_access_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import io_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, inj = 1'h0;
  logic [31:0] wdata = 32'h0, pin = 32'ha5b6c7d8;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, lr;
  logic [31:0] rdata, pout, v;
  int error_cnt = 0, check_count = 0, cyc = 0, rdy_n, mem_n;

  io_link_if u_io_link_if (.aclk(aclk), .aresetn(aresetn));
  io_port_unit u_io_port_unit (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .link(u_io_link_if));
  io_port_decoder u_io_port_decoder (.link(u_io_link_if),
    .user_port_out(pout), .user_port_in(pin),
    .user_parity_inject(inj));
  io_link_assertions u_io_link_assertions (.aclk(aclk),
    .aresetn(aresetn), .req(u_io_link_if.req),
    .mem_io(u_io_link_if.mem_io), .write(u_io_link_if.write),
    .addr(u_io_link_if.addr), .be(u_io_link_if.be),
    .wdata(u_io_link_if.wdata), .rdata(u_io_link_if.rdata),
    .ready(u_io_link_if.ready), .parity_err(u_io_link_if.parity_err),
    .cache_enable_input_n(u_io_link_if.cache_enable_input_n));

  // 100 mhz clock
  always #5 aclk = ~aclk;

  // count bus cycles, and the memory ones; cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (u_io_link_if.ready) begin
      rdy_n++;
      if (u_io_link_if.mem_io) mem_n++;
    end
    if (cyc == 8000) begin
      error_cnt++;
      test_done();
    end
  end

  // compare and count
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // axi write: address and data together, bready until bvalid
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, bo;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    bready <= 1'h1;
    bo = 1'h0;
    while (!bo) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      bo = bvalid;
      lr = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
  endtask : wr

  // axi read into v
  task rd(input logic [7:0] a);
    logic ta, ro;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    ro = 1'h0;
    while (!ro) begin
      @(negedge aclk);
      ta = arvalid & arready;
      ro = rvalid;
      v = rdata;
      lr = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end
    rready <= 1'h0;
  endtask : rd

  // start an operation and poll busy, bounded
  task op(input logic [31:0] c);
    int i;
    rdy_n = 0;
    mem_n = 0;
    wr(OFF_CTRL, c | 32'h1);
    i = 0;
    do begin
      rd(OFF_STAT);
      i++;
    end while (v[ST_BUSY] !== 1'h0 && i < 40);
    chk({31'h0, v[ST_BUSY]}, 32'h0);
  endtask : op

  // privileged access: fault flag and cycle count, then clear
  task priv(input logic [15:0] p, input logic [31:0] c,
            input logic g, input int n);
    wr(OFF_PORT, {16'h0, p});
    op(c);
    chk({31'h0, v[ST_FAULT]}, {31'h0, g});
    chk(rdy_n, n);
    wr(OFF_STAT, 32'h2);
  endtask : priv

  // memory cycle: cache status and one memory cycle
  task memop(input logic [31:0] a, input logic [31:0] c, input logic e);
    wr(OFF_IMM, a);
    op(c);
    chk({31'h0, v[ST_CACHE]}, {31'h0, e});
    chk(mem_n, 1);
  endtask : memop

  task test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    // unmapped register answers with an error
    wr(8'h30, 32'h1);
    chk(lr, RESP_SLVERR);
    rd(8'h30);
    chk(lr, RESP_SLVERR);
    $display("test regs ended");
    // aligned 32-bit out, port register
    wr(OFF_ACC, 32'h11223344);
    wr(OFF_PORT, 32'h0);
    op(32'h0a);
    chk(pout, 32'h11223344);
    chk(rdy_n, 1);
    chk(mem_n, 0);
    // 16-bit in, immediate port, upper half kept
    wr(OFF_ACC, 32'hffff0000);
    wr(OFF_IMM, 32'h4);
    op(32'h84);
    rd(OFF_ACC);
    chk(v, 32'hffffc7d8);
    // unaligned 32-bit out splits in two
    wr(OFF_ACC, 32'haabbccdd);
    wr(OFF_PORT, 32'h2);
    op(32'h0a);
    chk(pout, 32'hccdd3344);
    chk(rdy_n, 2);
    // single byte out
    wr(OFF_ACC, 32'h5a);
    wr(OFF_PORT, 32'h3);
    op(32'h02);
    chk(pout, 32'h5add3344);
    // past the top port: high bytes dropped
    wr(OFF_ACC, 32'hffffffff);
    wr(OFF_PORT, 32'hfffe);
    op(32'h08);
    chk(rdy_n, 1);
    rd(OFF_ACC);
    chk(v, 32'h0);
    $display("test register forms ended");
    // privilege: bitmap deny, level grant, bitmap grant, far port
    wr(OFF_MAP, 32'h00040000);
    priv(16'h0010, 32'h1c08, 1'h1, 0);
    priv(16'h0010, 32'h7c08, 1'h0, 1);
    priv(16'h0014, 32'h1c00, 1'h0, 1);
    priv(16'h0100, 32'h1c00, 1'h1, 0);
    $display("test privilege ended");
    // memory cycles: window, cacheable, page disable
    memop(32'h10, 32'h180, 1'h0);
    memop(32'h80, 32'h180, 1'h1);
    memop(32'h80, 32'h380, 1'h0);
    $display("test memory ended");
    // parity fault on a port read
    inj <= 1'h1;
    wr(OFF_PORT, 32'h4);
    op(32'h0);
    chk({31'h0, v[ST_PAR]}, 32'h1);
    inj <= 1'h0;
    // reserved ports answer nothing, accumulator cleared
    wr(OFF_PORT, 32'hf8);
    op(32'h08);
    rd(OFF_ACC);
    chk(v, 32'h0);
    // string out, three bytes, index up
    wr(OFF_BUF, 32'h44332211);
    wr(OFF_SRC, 32'h0);
    wr(OFF_CNT, 32'h3);
    wr(OFF_PORT, 32'h0);
    op(32'h32);
    chk(pout, 32'h5add3333);
    chk(rdy_n, 3);
    rd(OFF_SRC);
    chk(v, 32'h3);
    // string in, two bytes, index down
    wr(OFF_DST, 32'h5);
    wr(OFF_CNT, 32'h2);
    wr(OFF_PORT, 32'h4);
    op(32'h70);
    rd(OFF_DST);
    chk(v, 32'h3);
    rd(OFF_BUF + 8'h4);
    chk({16'h0, v[15:0]}, 32'hd8d8);
    $display("test strings ended");
    test_done();
  end
endmodule : test_io_port_access_unit
